// ---- include/mdcp_cfg.svh ----
/*
  Constants for the multidrop console protocol front-end: register offsets,
  reset values and character codes. Assumes inclusion by bare name.
*/
`ifndef MDCP_CFG_SVH
`define MDCP_CFG_SVH
// The message and status registers are known by word index; the byte address is four times it.
`define MDCP_IDX_PENDING   8'h1B
`define MDCP_IDX_GROUP     8'h1C
`define MDCP_IDX_LOCAL     8'h1D
`define MDCP_IDX_STATUS    8'h1E
`define MDCP_OFF_PENDING   (8'(`MDCP_IDX_PENDING * 8'h04))
`define MDCP_OFF_GROUP     (8'(`MDCP_IDX_GROUP * 8'h04))
`define MDCP_OFF_LOCAL     (8'(`MDCP_IDX_LOCAL * 8'h04))
`define MDCP_OFF_STATUS    (8'(`MDCP_IDX_STATUS * 8'h04))
`define MDCP_OFF_ESCAPE    8'h00
`define MDCP_OFF_CTRL      8'h04
`define MDCP_OFF_RXDATA    8'h08
`define MDCP_OFF_TXDATA    8'h0C
`define MDCP_OFF_FLAGS     8'h10
`define MDCP_OFF_IRQ_STAT  8'h20
`define MDCP_OFF_IRQ_EN    8'h24
`define MDCP_OFF_IRQ_CLR   8'h28
`define MDCP_ESC_RESET     8'h1B
`define MDCP_CH_CR         8'h0D
`define MDCP_CH_LF         8'h0A
`define MDCP_CH_COMMA      8'h2C
`define MDCP_CH_G          8'h47
`define MDCP_CH_ZERO       8'h30
`define MDCP_CH_A          8'h41
`define MDCP_CTRL_PROT_BIT 0
`define MDCP_IRQ_GROUP     0
`define MDCP_IRQ_LOCAL     1
`define MDCP_IRQ_ATTACH    2
`define MDCP_IRQ_RXCHAR    3
`define MDCP_IRQ_W         4
`endif

// ---- include/mdcp_pkg.sv ----
/*
  Types for the multidrop console protocol front-end.
  Assumes the constants header is compiled alongside.
*/
package mdcp_pkg;
  typedef enum logic [9:0] {
    MDCP_IDLE    = 10'b0000000001,
    MDCP_ADDR    = 10'b0000000010,
    MDCP_SEP     = 10'b0000000100,
    MDCP_HI      = 10'b0000001000,
    MDCP_LO      = 10'b0000010000,
    MDCP_END     = 10'b0000100000,
    MDCP_REPLY   = 10'b0001000000,
    MDCP_ACK     = 10'b0010000000,
    MDCP_SKIP    = 10'b0100000000,
    MDCP_STATACK = 10'b1000000000
  } mdcp_state_t;

  typedef enum logic [1:0] {
    MDCP_CMD_STAT  = 2'h0,
    MDCP_CMD_LOCAL = 2'h1,
    MDCP_CMD_GROUP = 2'h2
  } mdcp_cmd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } mdcp_char_t;
endpackage : mdcp_pkg

// ---- core/mdcp_frontend.sv ----
/*
  Character-level protocol front-end for a board on a multidrop console link,
  with an APB register slave and one level interrupt.
  Assumes received characters arrive as one-cycle strobes from a UART in the
  pclk domain, and that the UART accepts transmit characters on tx_ready.
*/
// The APB register port was left to the implementer.
// Overview of operation
// - Every command starts with the escape character, recognised anywhere in the stream.
// - The escape code comes from a writable configuration register, reset 1BH.
// - Escape detaches the local interpreter and starts command decoding.
// - After escape comes one upper-case hex address digit or G.
// - Addressed board echoes the message; held as pending until acknowledged.
// - Only the final carriage return commits pending; others discard; escape restarts.
// - CR is 0DH, LF 0AH; values are two hex characters after a comma.
// - Escape, address, CR interrogates status when protocol is enabled; board replies.
// - Interrogation without further acknowledgement leaves the console detached.
// - A CR after the status reply attaches the console to the interpreter.
// - Local message is echoed, stored on CR, and leaves the console attached.
// - Board 0 echoes a group message, then stores it on the master's CR.
// - Boards 1 to F stay silent and store the group value on second CR.
// - Differential transmit drives only while request-to-send is inactive.
// - Accepting a group message detaches the console.
// - Software output goes out only when attached; replies go out while detached; protocol off forces attach, but received characters pass only in IDLE.
// - Board address is taken from the first four configuration switches.
`timescale 1ns/10ps
`include "mdcp_cfg.svh"
module mdcp_frontend (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  input  wire logic        tx_ready,
  input  wire logic [3:0]  addr_switch,
  input  wire logic        protocol_strap,
  input  wire logic        rts_active,
  output logic             diff_tx_enable,
  output logic             attached,
  output logic             irq
);
  localparam int REPLY_LEN = 7;

  mdcp_pkg::mdcp_state_t state;
  mdcp_pkg::mdcp_cmd_t   cmd;
  mdcp_pkg::mdcp_char_t  rx;
  logic [7:0]  escape_code;
  logic [7:0]  pending_message;
  logic [7:0]  group_message;
  logic [7:0]  local_message;
  logic [7:0]  local_status;
  logic        protocol_on;
  logic [3:0]  board_addr;
  logic [3:0]  hi_nib;
  logic [2:0]  reply_idx;
  logic [7:0]  rx_hold;
  logic [7:0]  sw_tx;
  logic        sw_tx_pend;
  logic [`MDCP_IRQ_W-1:0] irq_stat;
  logic [`MDCP_IRQ_W-1:0] irq_en;
  logic [`MDCP_IRQ_W-1:0] irq_set;
  logic        strap_done;
  logic        is_hex;
  logic [3:0]  hex_val;
  logic        is_esc;
  logic        is_cr;
  logic        commit_group;
  logic        commit_local;
  logic        attach_evt;
  logic        pass_char;
  logic        wr;
  logic        rd;
  logic [7:0]  reply_char;
  logic [7:0]  reply_byte;

  function automatic logic [7:0] to_hex(input logic [3:0] v);
    to_hex = (v < 4'hA) ? (`MDCP_CH_ZERO + {4'h0, v}) : (`MDCP_CH_A + {4'h0, v} - 8'h0A);
  endfunction : to_hex

  assign rx.valid = rx_valid;
  assign rx.data  = rx_data;
  assign is_esc = rx.valid && protocol_on && (rx.data == escape_code);
  assign is_cr  = rx.data == `MDCP_CH_CR;

  // Upper-case digits only; lower-case letters are not hex here.
  always_comb begin
    is_hex  = 1'b0;
    hex_val = 4'h0;
    if (rx.data >= 8'h30 && rx.data <= 8'h39) begin
      is_hex  = 1'b1;
      hex_val = rx.data[3:0];
    end else if (rx.data >= 8'h41 && rx.data <= 8'h46) begin
      is_hex  = 1'b1;
      hex_val = rx.data[3:0] + 4'h9;
    end
  end

  // The switches are sampled once after reset release; they are not expected to move.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      board_addr  <= 4'h0;
      strap_done  <= 1'b0;
    end else if (!strap_done) begin
      board_addr  <= addr_switch;
      strap_done  <= 1'b1;
    end
  end

  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= mdcp_pkg::MDCP_IDLE;
      cmd       <= mdcp_pkg::MDCP_CMD_STAT;
      hi_nib    <= 4'h0;
      reply_idx <= 3'h0;
      pending_message <= 8'h00;
    end else if (is_esc) begin
      state <= mdcp_pkg::MDCP_ADDR;
    end else begin
      case (state)
        mdcp_pkg::MDCP_IDLE: begin
          state <= mdcp_pkg::MDCP_IDLE;
        end
        mdcp_pkg::MDCP_ADDR: if (rx.valid) begin
          if (rx.data == `MDCP_CH_G) begin
            cmd   <= mdcp_pkg::MDCP_CMD_GROUP;
            state <= mdcp_pkg::MDCP_SEP;
          end else if (is_hex && hex_val == board_addr) begin
            cmd   <= mdcp_pkg::MDCP_CMD_STAT;
            state <= mdcp_pkg::MDCP_SEP;
          end else begin
            state <= mdcp_pkg::MDCP_SKIP;
          end
        end
        mdcp_pkg::MDCP_SEP: if (rx.valid) begin
          if (rx.data == `MDCP_CH_COMMA) begin
            if (cmd == mdcp_pkg::MDCP_CMD_STAT) cmd <= mdcp_pkg::MDCP_CMD_LOCAL;
            state <= mdcp_pkg::MDCP_HI;
          end else if (is_cr && cmd == mdcp_pkg::MDCP_CMD_STAT) begin
            reply_idx <= 3'h0;
            state     <= mdcp_pkg::MDCP_REPLY;
          end else begin
            state <= mdcp_pkg::MDCP_SKIP;
          end
        end
        mdcp_pkg::MDCP_HI: if (rx.valid) begin
          hi_nib <= hex_val;
          state  <= is_hex ? mdcp_pkg::MDCP_LO : mdcp_pkg::MDCP_SKIP;
        end
        mdcp_pkg::MDCP_LO: if (rx.valid) begin
          pending_message <= {hi_nib, hex_val};
          state <= is_hex ? mdcp_pkg::MDCP_END : mdcp_pkg::MDCP_SKIP;
        end
        mdcp_pkg::MDCP_END: if (rx.valid) begin
          if (!is_cr) begin
            state <= mdcp_pkg::MDCP_SKIP;
          end else if (cmd == mdcp_pkg::MDCP_CMD_GROUP && board_addr != 4'h0) begin
            state <= mdcp_pkg::MDCP_ACK;
          end else begin
            reply_idx <= 3'h0;
            state     <= mdcp_pkg::MDCP_REPLY;
          end
        end
        mdcp_pkg::MDCP_REPLY: if (tx_ready) begin
          reply_idx <= reply_idx + 3'h1;
          if (reply_idx == 3'(REPLY_LEN - 1)) begin
            state <= (cmd == mdcp_pkg::MDCP_CMD_STAT) ? mdcp_pkg::MDCP_STATACK : mdcp_pkg::MDCP_ACK;
          end
        end
        mdcp_pkg::MDCP_ACK: if (rx.valid) begin
          state <= mdcp_pkg::MDCP_IDLE;
        end
        mdcp_pkg::MDCP_STATACK: if (rx.valid) begin
          state <= mdcp_pkg::MDCP_IDLE;
        end
        mdcp_pkg::MDCP_SKIP: begin
          state <= mdcp_pkg::MDCP_SKIP;
        end
        default: state <= mdcp_pkg::MDCP_IDLE;
      endcase
    end
  end

  assign commit_group = rx.valid && !is_esc && is_cr && state == mdcp_pkg::MDCP_ACK &&
                        cmd == mdcp_pkg::MDCP_CMD_GROUP;
  assign commit_local = rx.valid && !is_esc && is_cr && state == mdcp_pkg::MDCP_ACK &&
                        cmd == mdcp_pkg::MDCP_CMD_LOCAL;
  assign attach_evt   = commit_local ||
                        (rx.valid && !is_esc && is_cr && state == mdcp_pkg::MDCP_STATACK);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_message <= 8'h00;
      local_message <= 8'h00;
    end else begin
      if (commit_group) group_message <= pending_message;
      else if (wr && paddr[7:0] == `MDCP_OFF_GROUP) group_message <= pwdata[7:0];
      if (commit_local) local_message <= pending_message;
      else if (wr && paddr[7:0] == `MDCP_OFF_LOCAL) local_message <= pwdata[7:0];
    end
  end

  // Reset leaves the console attached until the first escape, so a board with
  // protocol off talks to the console straight away.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attached <= 1'b1;
    end else if (!protocol_on) begin
      attached <= 1'b1;
    end else if (is_esc || commit_group) begin
      attached <= 1'b0;
    end else if (attach_evt) begin
      attached <= 1'b1;
    end
  end

  // Characters outside a command reach the interpreter only when attached.
  assign pass_char = rx.valid && !is_esc && attached && state == mdcp_pkg::MDCP_IDLE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      escape_code  <= `MDCP_ESC_RESET;
      local_status <= 8'h00;
      protocol_on  <= 1'b0;
      rx_hold      <= 8'h00;
      sw_tx        <= 8'h00;
      sw_tx_pend   <= 1'b0;
      irq_en       <= '0;
    end else begin
      if (!strap_done) protocol_on <= protocol_strap;
      else if (wr && paddr[7:0] == `MDCP_OFF_CTRL) protocol_on <= pwdata[`MDCP_CTRL_PROT_BIT];
      if (wr && paddr[7:0] == `MDCP_OFF_ESCAPE) escape_code <= pwdata[7:0];
      if (wr && paddr[7:0] == `MDCP_OFF_STATUS) local_status <= pwdata[7:0];
      if (wr && paddr[7:0] == `MDCP_OFF_IRQ_EN) irq_en <= pwdata[`MDCP_IRQ_W-1:0];
      if (pass_char) rx_hold <= rx.data;
      if (wr && paddr[7:0] == `MDCP_OFF_TXDATA) begin
        sw_tx      <= pwdata[7:0];
        sw_tx_pend <= 1'b1;
      end else if (sw_tx_pend && tx_ready && attached && state != mdcp_pkg::MDCP_REPLY) begin
        sw_tx_pend <= 1'b0;
      end
    end
  end

  assign irq_set = {pass_char, attach_evt, commit_local, commit_group};

  // A new event in the cycle of its clear keeps the bit set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~((wr && paddr[7:0] == `MDCP_OFF_IRQ_CLR) ? pwdata[`MDCP_IRQ_W-1:0] : '0)) | irq_set;
    end
  end
  assign irq = |(irq_stat & irq_en);

  always_comb begin
    reply_byte = (cmd == mdcp_pkg::MDCP_CMD_STAT) ? local_status : pending_message;
    case (reply_idx)
      3'h0:    reply_char = (cmd == mdcp_pkg::MDCP_CMD_GROUP) ? `MDCP_CH_ZERO : to_hex(board_addr);
      3'h1:    reply_char = `MDCP_CH_COMMA;
      3'h2:    reply_char = to_hex(reply_byte[7:4]);
      3'h3:    reply_char = to_hex(reply_byte[3:0]);
      3'h4:    reply_char = 8'h20;
      3'h5:    reply_char = `MDCP_CH_CR;
      default: reply_char = `MDCP_CH_LF;
    endcase
  end

  // Echo and status replies take priority; software output waits behind them.
  // Software output reaches the link only while attached.
  assign tx_valid = (state == mdcp_pkg::MDCP_REPLY) || (sw_tx_pend && attached);
  assign tx_data  = (state == mdcp_pkg::MDCP_REPLY) ? reply_char : sw_tx;
  assign diff_tx_enable = !rts_active;

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      case (paddr[7:0])
        `MDCP_OFF_PENDING:  prdata = {24'h0, pending_message};
        `MDCP_OFF_GROUP:    prdata = {24'h0, group_message};
        `MDCP_OFF_LOCAL:    prdata = {24'h0, local_message};
        `MDCP_OFF_STATUS:   prdata = {24'h0, local_status};
        `MDCP_OFF_ESCAPE:   prdata = {24'h0, escape_code};
        `MDCP_OFF_CTRL:     prdata = {31'h0, protocol_on};
        `MDCP_OFF_RXDATA:   prdata = {24'h0, rx_hold};
        `MDCP_OFF_FLAGS:    prdata = {22'h0, state == mdcp_pkg::MDCP_IDLE, sw_tx_pend, board_addr, 3'h0, attached};
        `MDCP_OFF_IRQ_STAT: prdata = {28'h0, irq_stat};
        `MDCP_OFF_IRQ_EN:   prdata = {28'h0, irq_en};
        default:            prdata = 32'h0000_0000;
      endcase
    end
  end

  property p_esc_detach;
    @(posedge pclk) disable iff (!presetn) is_esc |=> !attached;
  endproperty
  a_esc_detach: assert property (p_esc_detach) else $error("escape did not detach");

  property p_esc_restart;
    @(posedge pclk) disable iff (!presetn) is_esc |=> state == mdcp_pkg::MDCP_ADDR;
  endproperty
  a_esc_restart: assert property (p_esc_restart) else $error("escape did not restart decode");

  property p_group_commit;
    @(posedge pclk) disable iff (!presetn) commit_group |=> group_message == $past(pending_message) && !attached;
  endproperty
  a_group_commit: assert property (p_group_commit) else $error("group byte not stored");

  property p_local_commit;
    @(posedge pclk) disable iff (!presetn) commit_local |=> local_message == $past(pending_message) && attached;
  endproperty
  a_local_commit: assert property (p_local_commit) else $error("local byte not stored");

  property p_no_tx_skip;
    @(posedge pclk) disable iff (!presetn) state == mdcp_pkg::MDCP_SKIP && !attached |-> !tx_valid;
  endproperty
  a_no_tx_skip: assert property (p_no_tx_skip) else $error("transmit while ignoring");

  property p_rts;
    @(posedge pclk) disable iff (!presetn) rts_active |-> !diff_tx_enable;
  endproperty
  a_rts: assert property (p_rts) else $error("driving with request-to-send active");

  property p_silent_group;
    @(posedge pclk) disable iff (!presetn) cmd == mdcp_pkg::MDCP_CMD_GROUP && board_addr != 4'h0 |-> state != mdcp_pkg::MDCP_REPLY;
  endproperty
  a_silent_group: assert property (p_silent_group) else $error("non-zero board replied to group");

  property p_reply_end;
    @(posedge pclk) disable iff (!presetn) state == mdcp_pkg::MDCP_REPLY && reply_idx == 3'h6 && tx_ready && !is_esc
      |=> state == mdcp_pkg::MDCP_STATACK || state == mdcp_pkg::MDCP_ACK;
  endproperty
  a_reply_end: assert property (p_reply_end) else $error("reply did not end after linefeed");

  property p_protocol_off;
    @(posedge pclk) disable iff (!presetn) !protocol_on |=> attached;
  endproperty
  a_protocol_off: assert property (p_protocol_off) else $error("console detached with protocol off");

  property p_status_attach;
    @(posedge pclk) disable iff (!presetn)
      state == mdcp_pkg::MDCP_STATACK && rx.valid && is_cr && !is_esc |=> attached;
  endproperty
  a_status_attach: assert property (p_status_attach) else $error("status acknowledge did not attach");

  property p_status_detach;
    @(posedge pclk) disable iff (!presetn)
      state == mdcp_pkg::MDCP_STATACK && !attached && rx.valid && !is_cr && protocol_on |=> !attached;
  endproperty
  a_status_detach: assert property (p_status_detach) else $error("status without acknowledge attached");

  property p_skip_hold;
    @(posedge pclk) disable iff (!presetn) state == mdcp_pkg::MDCP_SKIP && !is_esc |=> state == mdcp_pkg::MDCP_SKIP;
  endproperty
  a_skip_hold: assert property (p_skip_hold) else $error("ignoring ended without escape");

  property p_lower_refused;
    @(posedge pclk) disable iff (!presetn)
      state == mdcp_pkg::MDCP_ADDR && rx.valid && !is_esc && rx.data >= 8'h61 && rx.data <= 8'h66
      |=> state == mdcp_pkg::MDCP_SKIP;
  endproperty
  a_lower_refused: assert property (p_lower_refused) else $error("lower-case address accepted");

  property p_sw_tx_attached;
    @(posedge pclk) disable iff (!presetn) tx_valid && state != mdcp_pkg::MDCP_REPLY |-> attached;
  endproperty
  a_sw_tx_attached: assert property (p_sw_tx_attached) else $error("software output while detached");

  property p_reply_hold;
    @(posedge pclk) disable iff (!presetn)
      state == mdcp_pkg::MDCP_REPLY && !is_esc |=> pending_message == $past(pending_message);
  endproperty
  a_reply_hold: assert property (p_reply_hold) else $error("pending value moved during echo");
endmodule : mdcp_frontend

// ---- verification/mdcp_console.sv ----
/*
  Console model for the multidrop link: sends one character strobe at a time
  and collects the characters that the board transmits.
  Assumes the board and this model share one pclk domain.
*/
`timescale 1ns/10ps
module mdcp_console (
  input  wire logic       pclk,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic [7:0] got[$];
  logic       slow = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
  end
  // A slow console drops ready on alternate cycles so each reply stretches out.
  always @(posedge pclk) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
    end
    tx_ready <= slow ? !tx_ready : 1'b1;
  end
  // Between strobes the data lines show the inverse, so a stale value never matches.
  task automatic send(input logic [7:0] c);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_data  <= c;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_data  <= ~c;
    @(posedge pclk);
  endtask : send
endmodule : mdcp_console

// ---- verification/test_mdcp_frontend.sv ----
/*
  Self-checking bench for the console protocol front-end: APB registers,
  console command sequences and the interrupt.
  Assumes the design and the console model are compiled before it.
*/
`timescale 1ns/10ps
`include "mdcp_cfg.svh"
module test_mdcp_frontend;
  logic        pclk;
  logic        presetn;
  logic [31:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic        tx_ready;
  logic [3:0]  addr_switch;
  logic        protocol_strap;
  logic        rts_active;
  logic        diff_tx_enable;
  logic        attached;
  logic        irq;
  logic [31:0] rd;
  logic [7:0]  esc;
  int          errors;
  int          checked;

  mdcp_frontend i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .addr_switch(addr_switch), .protocol_strap(protocol_strap), .rts_active(rts_active),
    .diff_tx_enable(diff_tx_enable), .attached(attached), .irq(irq));
  mdcp_console i_con (.pclk(pclk), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    #200000;
    errors++;
    complete_run();
  end

  task automatic complete_run();
    $display("Counts: %0d errors, %0d checked", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // One idle edge follows each transfer so its write has landed before any look.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    paddr   <= {24'h0, a};
    pwrite  <= w;
    pwdata  <= d;
    psel    <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    if (n >= 50) errors++;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    check({24'h0, rd[7:0]}, {24'h0, exp});
  endtask : rchk

  task automatic do_reset(input logic [3:0] sw);
    presetn     <= 1'b0;
    addr_switch <= sw;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    i_con.got.delete();
    esc = `MDCP_ESC_RESET;
  endtask : do_reset

  // In a command string a caret stands for the escape code and a dot for CR.
  task automatic cmd(input string s);
    for (int i = 0; i < s.len(); i++) begin
      i_con.send(s[i] == "^" ? esc : (s[i] == "." ? `MDCP_CH_CR : s[i]));
    end
  endtask : cmd

  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction : hx

  task automatic reply(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] e[7];
    e = '{a, `MDCP_CH_COMMA, hx(v[7:4]), hx(v[3:0]), 8'h20, `MDCP_CH_CR, `MDCP_CH_LF};
    for (int n = 0; n < 300 && i_con.got.size() < 7; n++) @(posedge pclk);
    check(i_con.got.size(), 7);
    for (int i = 0; i < 7 && i < i_con.got.size(); i++) check(i_con.got[i], e[i]);
    i_con.got.delete();
  endtask : reply

  task automatic silent();
    repeat (40) @(posedge pclk);
    check(i_con.got.size(), 0);
    i_con.got.delete();
  endtask : silent

  initial begin
    presetn = 1'b0;
    paddr = 32'h0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    addr_switch = 4'h3;
    protocol_strap = 1'b1;
    rts_active = 1'b0;
    errors = 0;
    checked = 0;
    esc = `MDCP_ESC_RESET;
    do_reset(4'h3);
    check(attached, 1'b1);
    check(irq, 1'b0);
    rchk(`MDCP_OFF_ESCAPE, 8'h1B);
    rchk(`MDCP_OFF_IRQ_STAT, 8'h00);
    rchk(8'h3C, 8'h00);
    apb(1'b0, `MDCP_OFF_FLAGS, 32'h0);
    check(rd[7:4], 4'h3);
    check(diff_tx_enable, 1'b1);
    rts_active <= 1'b1;
    @(posedge pclk);
    @(posedge pclk);
    check(diff_tx_enable, 1'b0);
    rts_active <= 1'b0;
    i_con.slow = 1'b1;
    apb(1'b1, `MDCP_OFF_IRQ_EN, 32'h2);
    cmd("^3,42.");
    check(attached, 1'b0);
    reply("3", 8'h42);
    rchk(`MDCP_OFF_PENDING, 8'h42);
    check(irq, 1'b0);
    cmd(".");
    rchk(`MDCP_OFF_LOCAL, 8'h42);
    check(attached, 1'b1);
    check(irq, 1'b1);
    apb(1'b1, `MDCP_OFF_IRQ_CLR, 32'h2);
    check(irq, 1'b0);
    i_con.slow = 1'b0;
    cmd("^3,99.");
    reply("3", 8'h99);
    cmd("X");
    rchk(`MDCP_OFF_LOCAL, 8'h42);
    cmd("^3,1^3,55.");
    reply("3", 8'h55);
    cmd(".");
    rchk(`MDCP_OFF_LOCAL, 8'h55);
    apb(1'b1, `MDCP_OFF_STATUS, 32'hA5);
    cmd("^3.");
    reply("3", 8'hA5);
    check(attached, 1'b0);
    cmd(".");
    check(attached, 1'b1);
    cmd("^3.");
    reply("3", 8'hA5);
    cmd("Q");
    check(attached, 1'b0);
    cmd("^5,12..^5.");
    silent();
    rchk(`MDCP_OFF_LOCAL, 8'h55);
    cmd("^a.");
    silent();
    cmd("^G,7E.");
    silent();
    check(attached, 1'b0);
    cmd(".");
    rchk(`MDCP_OFF_GROUP, 8'h7E);
    rchk(`MDCP_OFF_IRQ_STAT, 8'h07);
    check(irq, 1'b1);
    apb(1'b1, `MDCP_OFF_IRQ_CLR, 32'h7);
    rchk(`MDCP_OFF_IRQ_STAT, 8'h00);
    check(irq, 1'b0);
    apb(1'b1, `MDCP_OFF_ESCAPE, 32'h7E);
    esc = 8'h7E;
    cmd("^3.");
    reply("3", 8'hA5);
    apb(1'b1, `MDCP_OFF_CTRL, 32'h0);
    cmd("^3.");
    silent();
    rchk(`MDCP_OFF_RXDATA, `MDCP_CH_CR);
    apb(1'b1, `MDCP_OFF_TXDATA, 32'h55);
    repeat (4) @(posedge pclk);
    check(i_con.got.size(), 1);
    check(i_con.got.size() > 0 ? {24'h0, i_con.got[0]} : 32'h0, 32'h55);
    do_reset(4'hA);
    cmd("^a.");
    silent();
    cmd("^A.");
    reply("A", 8'h00);
    do_reset(4'h0);
    cmd("^G,3C.");
    reply("0", 8'h3C);
    cmd(".");
    rchk(`MDCP_OFF_GROUP, 8'h3C);
    check(attached, 1'b0);
    complete_run();
  end
endmodule : test_mdcp_frontend
